// >>> mms_pkg.sv
// Shared constants, types and helpers of the motion module serial command block
package mms_pkg;

  // Clock and link timing
  localparam int CLK_HZ         = 125_000_000;
  localparam int BAUD_RATE      = 9600;
  localparam int BIT_CYCLES     = (CLK_HZ + BAUD_RATE / 2) / BAUD_RATE;
  localparam int TIMEOUT_MS     = 2500;
  localparam int TIMEOUT_CYCLES = (CLK_HZ / 1000) * TIMEOUT_MS;
  localparam int SECOND_CYCLES  = CLK_HZ;
  localparam int FRAME_BITS     = 10;

  // Command characters
  localparam logic [7:0] CMD_RD_STATUS = 8'h61;
  localparam logic [7:0] CMD_RD_LIGHT  = 8'h62;
  localparam logic [7:0] CMD_RD_PIN    = 8'h63;
  localparam logic [7:0] CMD_RD_ACT    = 8'h64;
  localparam logic [7:0] CMD_RD_HYPER  = 8'h65;
  localparam logic [7:0] CMD_RD_FREQ   = 8'h66;
  localparam logic [7:0] CMD_RD_LEVEL  = 8'h67;
  localparam logic [7:0] CMD_RD_SUSP   = 8'h68;
  localparam logic [7:0] CMD_RD_THRESH = 8'h6c;
  localparam logic [7:0] CMD_RD_OUT    = 8'h6f;
  localparam logic [7:0] CMD_RD_DIR    = 8'h76;
  localparam logic [7:0] CMD_WR_PIN    = 8'h43;
  localparam logic [7:0] CMD_WR_ACT    = 8'h44;
  localparam logic [7:0] CMD_WR_HYPER  = 8'h45;
  localparam logic [7:0] CMD_WR_FREQ   = 8'h46;
  localparam logic [7:0] CMD_WR_LEVEL  = 8'h47;
  localparam logic [7:0] CMD_WR_SUSP   = 8'h48;
  localparam logic [7:0] CMD_WR_THRESH = 8'h4c;
  localparam logic [7:0] CMD_WR_OUT    = 8'h4f;
  localparam logic [7:0] CMD_WR_DIR    = 8'h56;
  localparam logic [7:0] LOWER_CASE    = 8'h20;

  // Reply and data characters
  localparam logic [7:0] CH_YES   = 8'h59;
  localparam logic [7:0] CH_NO    = 8'h4e;
  localparam logic [7:0] CH_UNST  = 8'h55;
  localparam logic [7:0] CH_HIGH  = 8'h48;
  localparam logic [7:0] CH_LOW   = 8'h4c;
  localparam logic [7:0] CH_MOT   = 8'h4d;
  localparam logic [7:0] CH_RST   = 8'h52;
  localparam logic [7:0] CH_ANY   = 8'h41;
  localparam logic [7:0] CH_PLUS  = 8'h2b;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam logic [7:0] CH_ACK   = 8'h06;
  localparam logic [7:0] CH_NACK  = 8'h15;
  localparam logic [7:0] LEVEL_LIMIT = 8'h04;
  localparam logic [7:0] BYTE_MAX    = 8'hff;

  // Activation time coding
  localparam logic [7:0]  ACT_OFF_SEC = 8'h00;
  localparam logic [7:0]  ACT_OFF_MIN = 8'h80;
  localparam logic [13:0] SEC_PER_MIN = 14'h003c;

  typedef enum logic [1:0] {DIR_ANY, DIR_POS, DIR_NEG} mms_dir_t;

  typedef struct packed {
    logic [7:0] activation;
    logic       hyperEn;
    logic       freqHigh;
    logic [1:0] hyperLevel;
    logic       suspend;
    mms_dir_t   direction;
    logic       pinMotion;
    logic [7:0] threshold;
  } mms_cfg_t;

  localparam mms_cfg_t CFG_DEFAULT = '{
    activation: 8'h02, hyperEn: 1'b0, freqHigh: 1'b0, hyperLevel: 2'h1,
    suspend: 1'b0, direction: DIR_ANY, pinMotion: 1'b0, threshold: 8'h64};

  typedef enum {ST_IDLE, ST_REPLY, ST_WAIT_DATA} mms_state_t;

  // APB map
  localparam logic [11:0] ADDR_THRESH = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam int ST_BIT_LATCH  = 0;
  localparam int ST_BIT_ACTIVE = 1;
  localparam int ST_BIT_STABLE = 2;
  localparam int ST_BIT_WAIT   = 3;
  localparam int ST_BIT_PINMOT = 4;
  localparam int ST_LIGHT_LSB  = 8;

  // Activation code to seconds; both off codes give zero
  function automatic logic [13:0] mms_act_seconds(input logic [7:0] code);
    if (code == ACT_OFF_SEC || code == ACT_OFF_MIN)
      return 14'h0000;
    if (code < ACT_OFF_MIN)
      return {6'h00, code};
    return {6'h00, 8'(code - ACT_OFF_MIN)} * SEC_PER_MIN;
  endfunction

endpackage

// >>> mms_serial_cmd.sv
// Serial command interpreter of the motion module, with APB side registers
`timescale 1ns/1ns
module mms_serial_cmd
  import mms_pkg::*;
#(
  parameter int BIT_CYC     = BIT_CYCLES,
  parameter int TIMEOUT_CYC = TIMEOUT_CYCLES,
  parameter int SECOND_CYC  = SECOND_CYCLES
)(
  input  logic        mclk,
  input  logic        rst,
  input  logic        rxd,
  output logic        txd,
  input  logic [7:0]  lightLevel,
  input  logic        motionEvent,
  input  logic        sensorStable,
  input  logic        sharedPinIn,
  output logic        sharedPinOut,
  output logic        sharedPinOe,
  output logic        deviceReset,
  input  logic [11:0] paddr,
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr
);

  localparam int BW = $clog2(BIT_CYC + 1);
  localparam int TW = $clog2(TIMEOUT_CYC + 1);
  localparam int SW = $clog2(SECOND_CYC + 1);

  logic [1:0]    rxSync;
  logic [1:0]    pinSync;
  logic          rxBusy;
  logic [BW-1:0] rxCnt;
  logic [3:0]    rxIdx;
  logic [7:0]    rxShift;
  logic          rxValid;
  logic [7:0]    rxByte;
  logic          txBusy;
  logic          txStart;
  logic [BW-1:0] txCnt;
  logic [3:0]    txIdx;
  logic [9:0]    txShift;
  mms_state_t    state;
  mms_state_t    replyNext;
  logic [7:0]    replyByte;
  logic [7:0]    pendCmd;
  logic [TW-1:0] waitCnt;
  mms_cfg_t      cfg;
  logic          motionLatched;
  logic          motionSet;
  logic          statusClear;
  logic          dataApply;
  logic          pinReset;
  logic [SW-1:0] secCnt;
  logic          secTick;
  logic [13:0]   actRemain;
  logic          actManual;
  logic          motionActive;
  logic [7:0]    outTime;
  logic          apbWrite;
  logic [8:0]    rdAns;
  logic [8:0]    rdEcho;

  // Answer byte for a lower-case command; bit 8 flags a known command
  function automatic logic [8:0] read_value(input logic [7:0] ch);
    unique case (ch)
      CMD_RD_STATUS: return {1'b1, !sensorStable ? CH_UNST :
                                   (motionLatched ? CH_YES : CH_NO)};
      CMD_RD_LIGHT:  return {1'b1, lightLevel};
      CMD_RD_PIN:    return {1'b1, cfg.pinMotion ? CH_MOT : CH_RST};
      CMD_RD_ACT:    return {1'b1, cfg.activation};
      CMD_RD_HYPER:  return {1'b1, cfg.hyperEn ? CH_YES : CH_NO};
      CMD_RD_FREQ:   return {1'b1, cfg.freqHigh ? CH_HIGH : CH_LOW};
      CMD_RD_LEVEL:  return {1'b1, 6'h00, cfg.hyperLevel};
      CMD_RD_SUSP:   return {1'b1, cfg.suspend ? CH_YES : CH_NO};
      CMD_RD_THRESH: return {1'b1, cfg.threshold};
      CMD_RD_OUT:    return {1'b1, outTime};
      CMD_RD_DIR:    return {1'b1, cfg.direction == DIR_POS ? CH_PLUS :
                                   cfg.direction == DIR_NEG ? CH_MINUS : CH_ANY};
      default:       return {1'b0, CH_NACK};
    endcase
  endfunction

  // Upper-case commands that take one data byte
  function automatic logic is_write(input logic [7:0] ch);
    unique case (ch)
      CMD_WR_PIN, CMD_WR_ACT, CMD_WR_HYPER, CMD_WR_FREQ, CMD_WR_LEVEL,
      CMD_WR_SUSP, CMD_WR_THRESH, CMD_WR_OUT, CMD_WR_DIR: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // Data byte legal for the pending write
  function automatic logic write_ok(input logic [7:0] cmd, input logic [7:0] d);
    unique case (cmd)
      CMD_WR_PIN:   return d == CH_MOT || d == CH_RST;
      CMD_WR_HYPER,
      CMD_WR_SUSP:  return d == CH_YES || d == CH_NO;
      CMD_WR_FREQ:  return d == CH_HIGH || d == CH_LOW;
      CMD_WR_LEVEL: return d < LEVEL_LIMIT;
      CMD_WR_DIR:   return d == CH_ANY || d == CH_PLUS || d == CH_MINUS;
      default:      return 1'b1;
    endcase
  endfunction

  // Two-stage synchronisers for the pins
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rxSync  <= 2'h3;
      pinSync <= 2'h3;
    end
    else
    begin
      rxSync  <= {rxSync[0], rxd};
      // Own drive masked, so a switch to reset mode never sees our own low
      pinSync <= sharedPinOe ? 2'h3 : {pinSync[0], sharedPinIn};
    end
  end

  // Reset-configured pin held low resets settings, sequencer, status latch and activation timer
  assign pinReset    = !cfg.pinMotion && !pinSync[1];
  assign deviceReset = pinReset;

  // Receiver: mid-bit sampling, false starts dropped, framing errors discarded
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rxBusy  <= 1'b0;
      rxCnt   <= '0;
      rxIdx   <= 4'h0;
      rxShift <= 8'h00;
      rxValid <= 1'b0;
      rxByte  <= 8'h00;
    end
    else
    begin
      rxValid <= 1'b0;
      if (!rxBusy)
      begin
        if (!rxSync[1])
        begin
          rxBusy <= 1'b1;
          rxCnt  <= BW'(BIT_CYC / 2);
          rxIdx  <= 4'h0;
        end
      end
      else if (rxCnt != '0)
        rxCnt <= rxCnt - 1'b1;
      else
      begin
        rxCnt <= BW'(BIT_CYC - 1);
        rxIdx <= rxIdx + 4'h1;
        if (rxIdx == 4'h0)
        begin
          if (rxSync[1])
            rxBusy <= 1'b0;
        end
        else if (rxIdx < 4'(FRAME_BITS - 1))
          rxShift <= {rxSync[1], rxShift[7:1]};
        else
        begin
          rxBusy <= 1'b0;
          if (rxSync[1])
          begin
            rxValid <= 1'b1;
            rxByte  <= rxShift;
          end
        end
      end
    end
  end

  // Transmitter: start, eight data bits LSB first, one stop bit
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      txBusy  <= 1'b0;
      txCnt   <= '0;
      txIdx   <= 4'h0;
      txShift <= 10'h3ff;
      txd     <= 1'b1;
    end
    else
    begin
      txd <= txBusy ? txShift[0] : 1'b1;
      if (!txBusy)
      begin
        if (txStart)
        begin
          txBusy  <= 1'b1;
          txShift <= {1'b1, replyByte, 1'b0};
          txCnt   <= '0;
          txIdx   <= 4'h0;
        end
      end
      else if (txCnt != BW'(BIT_CYC - 1))
        txCnt <= txCnt + 1'b1;
      else
      begin
        txCnt   <= '0;
        txShift <= {1'b1, txShift[9:1]};
        if (txIdx == 4'(FRAME_BITS - 1))
          txBusy <= 1'b0;
        else
          txIdx <= txIdx + 4'h1;
      end
    end
  end

  // Answers for the received byte, as a read and as the echo of a write
  assign rdAns  = read_value(rxByte);
  assign rdEcho = read_value(rxByte | LOWER_CASE);

  // Command events seen by the other processes
  assign statusClear = state == ST_IDLE && rxValid && rxByte == CMD_RD_STATUS;
  assign dataApply   = state == ST_WAIT_DATA && rxValid && write_ok(pendCmd, rxByte);

  // Command sequencer; bytes arriving while a reply waits are dropped
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state     <= ST_IDLE;
      replyNext <= ST_IDLE;
      replyByte <= CH_NACK;
      pendCmd   <= 8'h00;
      waitCnt   <= '0;
      txStart   <= 1'b0;
    end
    else if (pinReset)
    begin
      state   <= ST_IDLE;
      txStart <= 1'b0;
    end
    else
    begin
      txStart <= 1'b0;
      unique case (state)
        ST_IDLE:
          if (rxValid)
          begin
            state <= ST_REPLY;
            if (is_write(rxByte))
            begin
              replyByte <= rdEcho[8] ? rdEcho[7:0] : CH_NACK;
              pendCmd   <= rxByte;
              replyNext <= ST_WAIT_DATA;
            end
            else
            begin
              replyByte <= rdAns[8] ? rdAns[7:0] : CH_NACK;
              replyNext <= ST_IDLE;
            end
          end
        ST_REPLY:
          if (!txBusy && !txStart)
          begin
            txStart <= 1'b1;
            state   <= replyNext;
            waitCnt <= '0;
          end
        ST_WAIT_DATA:
          if (rxValid)
          begin
            replyByte <= dataApply ? CH_ACK : CH_NACK;
            replyNext <= ST_IDLE;
            state     <= ST_REPLY;
          end
          else if (waitCnt == TW'(TIMEOUT_CYC - 1))
          begin
            replyByte <= CH_NACK;
            replyNext <= ST_IDLE;
            state     <= ST_REPLY;
          end
          else
            waitCnt <= waitCnt + 1'b1;
      endcase
    end
  end

  // Settings; serial write wins over an APB write in the same cycle
  assign apbWrite = psel && penable && pwrite && paddr == ADDR_THRESH;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      cfg <= CFG_DEFAULT;
    else if (pinReset)
      cfg <= CFG_DEFAULT;
    else if (dataApply)
    begin
      unique case (pendCmd)
        CMD_WR_PIN:    cfg.pinMotion  <= rxByte == CH_MOT;
        CMD_WR_ACT:    cfg.activation <= rxByte;
        CMD_WR_HYPER:  cfg.hyperEn    <= rxByte == CH_YES;
        CMD_WR_FREQ:   cfg.freqHigh   <= rxByte == CH_HIGH;
        CMD_WR_LEVEL:  cfg.hyperLevel <= rxByte[1:0];
        CMD_WR_SUSP:   cfg.suspend    <= rxByte == CH_YES;
        CMD_WR_THRESH: cfg.threshold  <= rxByte;
        CMD_WR_DIR:    cfg.direction  <= rxByte == CH_PLUS ? DIR_POS :
                                         rxByte == CH_MINUS ? DIR_NEG : DIR_ANY;
        default:       cfg.pinMotion  <= cfg.pinMotion;
      endcase
    end
    else if (apbWrite)
      cfg.threshold <= pwdata[7:0];
  end

  // Motion status latch; a new event beats a clearing read
  assign motionSet = motionEvent && sensorStable && !cfg.suspend;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      motionLatched <= 1'b0;
    else if (pinReset)
      motionLatched <= 1'b0;
    else
      motionLatched <= motionSet || (motionLatched && !statusClear);
  end

  // One-second tick for the activation timer
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      secCnt  <= '0;
      secTick <= 1'b0;
    end
    else
    begin
      secTick <= secCnt == SW'(SECOND_CYC - 1);
      secCnt  <= secCnt == SW'(SECOND_CYC - 1) ? '0 : secCnt + 1'b1;
    end
  end

  // Activation timer; manual drive from O is not light gated
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      actRemain <= 14'h0000;
      actManual <= 1'b0;
    end
    else if (pinReset)
    begin
      actRemain <= 14'h0000;
      actManual <= 1'b0;
    end
    else if (dataApply && pendCmd == CMD_WR_OUT)
    begin
      actRemain <= mms_act_seconds(rxByte);
      actManual <= mms_act_seconds(rxByte) != 14'h0000; // Off codes hand back to motion
    end
    else if (motionSet && !actManual)
      actRemain <= mms_act_seconds(cfg.activation);
    else if (secTick && actRemain != 14'h0000)
    begin
      actRemain <= actRemain - 14'h0001;
      if (actRemain == 14'h0001)
        actManual <= 1'b0;
    end
  end

  // Light gate: strictly above threshold lets motion through
  assign motionActive = actRemain != 14'h0000 &&
                        (actManual || lightLevel > cfg.threshold);
  assign outTime = actRemain > {6'h00, BYTE_MAX} ? BYTE_MAX : actRemain[7:0];

  // Shared pin output, active low motion signal
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      sharedPinOut <= 1'b1;
      sharedPinOe  <= 1'b0;
    end
    else
    begin
      sharedPinOut <= !motionActive;
      sharedPinOe  <= cfg.pinMotion;
    end
  end

  // APB slave, zero wait states, read data captured in the setup cycle
  assign pready = 1'b1;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (psel && !penable)
    begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
      if (paddr == ADDR_THRESH)
        prdata[7:0] <= cfg.threshold;
      else if (paddr == ADDR_STATUS)
      begin
        prdata[ST_BIT_LATCH]  <= motionLatched;
        prdata[ST_BIT_ACTIVE] <= motionActive;
        prdata[ST_BIT_STABLE] <= sensorStable;
        prdata[ST_BIT_WAIT]   <= state == ST_WAIT_DATA;
        prdata[ST_BIT_PINMOT] <= cfg.pinMotion;
        prdata[ST_LIGHT_LSB +: 8] <= lightLevel;
      end
      else
        pslverr <= 1'b1;
    end
  end

endmodule // mms_serial_cmd

// >>> mms_serial_cmd_chk.sv
// Assertions on the ports of the motion module serial command block
`timescale 1ns/1ns
module mms_serial_cmd_chk
  import mms_pkg::*;
(
  input logic        mclk,
  input logic        rst,
  input logic        txd,
  input logic [7:0]  lightLevel,
  input logic        sensorStable,
  input logic        sharedPinIn,
  input logic        sharedPinOut,
  input logic        sharedPinOe,
  input logic        deviceReset,
  input logic [11:0] paddr,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // Setup cycle of a status read; only trusted when its source held still
  logic stRd;
  assign stRd = psel && !penable && !pwrite && paddr == ADDR_STATUS;

  property p_ready; psel && penable |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low in access");
  property p_err;
    psel && !penable && paddr != ADDR_THRESH && paddr != ADDR_STATUS |=> pslverr && prdata == 32'h0;
  endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  property p_thresh;
    psel && penable && pwrite && paddr == ADDR_THRESH ##1 psel && !penable && !pwrite
      && paddr == ADDR_THRESH |=> prdata == {24'h0, $past(pwdata[7:0], 2)};
  endproperty
  a_thresh: assert property (p_thresh) else $error("threshold readback wrong");
  property p_light; stRd && $stable(lightLevel) |=> prdata[15:8] == $past(lightLevel); endproperty
  a_light: assert property (p_light) else $error("light level field wrong");
  property p_stable;
    stRd && $stable(sensorStable) |=> prdata[ST_BIT_STABLE] == $past(sensorStable);
  endproperty
  a_stable: assert property (p_stable) else $error("stable flag wrong");
  property p_pinmot;
    stRd && $stable(sharedPinOe) |=> prdata[ST_BIT_PINMOT] == $past(sharedPinOe);
  endproperty
  a_pinmot: assert property (p_pinmot) else $error("pin mode flag wrong");
  property p_rstpin; deviceReset |-> $past(sharedPinIn, 2) == 1'b0; endproperty
  a_rstpin: assert property (p_rstpin) else $error("reset without low pin");
  property p_rstoe; deviceReset |-> !sharedPinOe; endproperty
  a_rstoe: assert property (p_rstoe) else $error("reset while pin driven");
  property p_start; $fell(txd) |-> !txd [*8]; endproperty
  a_start: assert property (p_start) else $error("start bit too short");

  // Main scenarios reached
  c_err: cover property (psel && penable && pslverr);
  c_rst: cover property (deviceReset);
  c_tx: cover property ($fell(txd));
  c_out: cover property (sharedPinOe && !sharedPinOut);
endmodule // mms_serial_cmd_chk

bind mms_serial_cmd mms_serial_cmd_chk u_chk (
  .mclk, .rst, .txd, .lightLevel, .sensorStable, .sharedPinIn, .sharedPinOut,
  .sharedPinOe, .deviceReset, .paddr, .psel, .penable, .pwrite, .pwdata,
  .prdata, .pready, .pslverr
);

// >>> mms_host_model.sv
// Host side of the serial link: sends commands, collects replies
`timescale 1ns/1ns
module mms_host_model #(
  parameter int BIT_CYC = 16
)(
  input  logic mclk,
  input  logic txd,
  output logic rxd
);
  initial rxd = 1'b1;

  // One 8N1 frame, LSB first; idle high between frames
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      rxd <= f[i];
      repeat (BIT_CYC) @(posedge mclk);
    end
  endtask

  // Bounded wait for a start bit, then mid-bit sampling
  task automatic recv(input int lim, output logic [7:0] b, output bit ok);
    int n;
    n = 0;
    ok = 1'b0;
    b = 8'h00;
    while (txd !== 1'b0 && n < lim)
    begin
      @(posedge mclk);
      n++;
    end
    if (txd === 1'b0)
    begin
      repeat (BIT_CYC / 2) @(posedge mclk);
      for (int i = 0; i < 8; i++)
      begin
        repeat (BIT_CYC) @(posedge mclk);
        b[i] = txd;
      end
      repeat (BIT_CYC) @(posedge mclk);
      ok = (txd === 1'b1);
    end
  endtask
endmodule // mms_host_model

// >>> tb.sv
// Self-checking bench of the motion module serial command block
`timescale 1ns/1ns
module tb
  import mms_pkg::*;
;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  lightLevel = 8'h00;
  logic        motionEvent = 1'b0;
  logic        sensorStable = 1'b0;
  logic        extPin = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic        rxd, txd, sharedPinOut, sharedPinOe, deviceReset, pready, pslverr, pinWire;
  logic [31:0] prdata;
  int          mismatches = 0;
  int          total_checks = 0;
  int          cyc = 0;

  mms_serial_cmd #(.BIT_CYC(16), .TIMEOUT_CYC(2000), .SECOND_CYC(50)) dut (
    .mclk(mclk), .rst(rst), .rxd(rxd), .txd(txd), .lightLevel(lightLevel),
    .motionEvent(motionEvent), .sensorStable(sensorStable), .sharedPinIn(pinWire),
    .sharedPinOut(sharedPinOut), .sharedPinOe(sharedPinOe), .deviceReset(deviceReset),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  mms_host_model #(.BIT_CYC(16)) host (.mclk(mclk), .txd(txd), .rxd(rxd));

  // Pull-up on the shared pin whenever the block does not drive it
  assign pinWire = sharedPinOe ? sharedPinOut : extPin;

  initial forever #4 mclk = ~mclk;

  // Hang guard, well above the length of the sequence
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Motion output level expected: active low, gated unless strictly above threshold
  function automatic logic expOut(input logic [7:0] lv, input logic [7:0] th);
    return !(lv > th);
  endfunction

  // APB transfer; request held until pready is seen high; nxt keeps psel for a setup next
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input bit nxt,
                     output logic [31:0] r, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
      @(posedge mclk);
    r = prdata;
    e = pslverr;
    if (!nxt)
    begin
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // Byte out and reply in run together: the reply may start inside our stop bit
  task automatic xfer(input logic [7:0] c, input logic [7:0] exp);
    logic [7:0] b;
    bit         ok;
    fork
      host.send(c);
      host.recv(5000, b, ok);
    join
    chk("reply", 32'({ok, b}), 32'({1'b1, exp}));
    repeat (20) @(posedge mclk);
  endtask

  task automatic pulse();
    motionEvent <= 1'b1;
    @(posedge mclk);
    motionEvent <= 1'b0;
    @(posedge mclk);
  endtask

  initial
  begin
    logic [31:0] r;
    logic        e;
    logic [7:0]  rt, rd, b;
    bit          ok;
    logic [7:0]  rc[9], rx[9], wc[9], wo[9], wn[9];
    void'($urandom(32'hba8dc484));
    rt = 8'h01 + 8'($urandom % 254);
    rd = 8'h01 + 8'($urandom % 127);
    rc = '{CMD_RD_THRESH, CMD_RD_PIN, CMD_RD_ACT, CMD_RD_HYPER, CMD_RD_FREQ,
           CMD_RD_LEVEL, CMD_RD_SUSP, CMD_RD_DIR, CMD_RD_OUT};
    rx = '{8'h64, CH_RST, 8'h02, CH_NO, CH_LOW, 8'h01, CH_NO, CH_ANY, 8'h00};
    wc = '{CMD_WR_PIN, CMD_WR_THRESH, CMD_WR_ACT, CMD_WR_HYPER, CMD_WR_FREQ,
           CMD_WR_LEVEL, CMD_WR_SUSP, CMD_WR_SUSP, CMD_WR_DIR};
    wo = '{CH_RST, 8'h64, 8'h02, CH_NO, CH_LOW, 8'h01, CH_NO, CH_YES, CH_ANY};
    wn = '{CH_MOT, rt, rd, CH_YES, CH_HIGH, 8'h03, CH_YES, CH_NO, CH_MINUS};
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk("txd idle", 32'(txd), 32'h1);
    chk("pin oe", 32'(sharedPinOe), 32'h0);
    foreach (rc[i]) xfer(rc[i], rx[i]);
    // Manual drive at light level zero: not gated, ends after its seconds
    xfer(CMD_WR_OUT, 8'h00);
    xfer(8'h05, CH_ACK);
    chk("manual out", 32'(sharedPinOut), 32'h0);
    repeat (300) @(posedge mclk);
    chk("manual end", 32'(sharedPinOut), 32'h1);
    xfer(CMD_RD_OUT, 8'h00);
    // Status latch: unsettled sensor, clear, set, clear again
    xfer(CMD_RD_STATUS, CH_UNST);
    sensorStable <= 1'b1;
    @(posedge mclk);
    xfer(CMD_RD_STATUS, CH_NO);
    pulse();
    xfer(CMD_RD_STATUS, CH_YES);
    xfer(CMD_RD_STATUS, CH_NO);
    // Light level at both ends of the range and at random
    for (int i = 0; i < 4; i++)
    begin
      lightLevel <= (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
      @(posedge mclk);
      xfer(CMD_RD_LIGHT, lightLevel);
      apb(1'b0, ADDR_STATUS, 32'h0, 1'b0, r, e);
      chk("status light", 32'(r[15:8]), 32'(lightLevel));
    end
    apb(1'b0, 12'h008, 32'h0, 1'b0, r, e);
    chk("bad addr err", 32'(e), 32'h1);
    chk("bad addr data", r, 32'h0);
    // Every write command but O: echo old, ACK, read back
    foreach (wc[i])
    begin
      xfer(wc[i], wo[i]);
      xfer(wn[i], CH_ACK);
      xfer(wc[i] | LOWER_CASE, wn[i]);
    end
    // APB write then read at once, seen on the serial side too, then restored
    apb(1'b1, ADDR_THRESH, {24'h000000, ~rt}, 1'b1, r, e);
    apb(1'b0, ADDR_THRESH, 32'h0, 1'b0, r, e);
    chk("thresh apb", r, {24'h000000, ~rt});
    xfer(CMD_RD_THRESH, ~rt);
    apb(1'b1, ADDR_THRESH, 32'(rt), 1'b0, r, e);
    // Refusals: illegal level, unknown command, missing data
    xfer(CMD_WR_LEVEL, 8'h03);
    xfer(LEVEL_LIMIT, CH_NACK);
    xfer(8'h71, CH_NACK);
    xfer(CMD_WR_HYPER, CH_YES);
    host.recv(5000, b, ok);
    chk("timeout nack", 32'({ok, b}), 32'({1'b1, CH_NACK}));
    // Light gate just below and just above the threshold
    chk("pin oe", 32'(sharedPinOe), 32'h1);
    for (int i = 0; i < 2; i++)
    begin
      lightLevel <= (i == 0) ? rt - 8'h01 : rt + 8'h01;
      pulse();
      repeat (4) @(posedge mclk);
      chk("motion out", 32'(sharedPinOut), 32'(expOut(lightLevel, rt)));
    end
    // Back to reset mode, then pull the pin low
    xfer(CMD_WR_PIN, CH_MOT);
    xfer(CH_RST, CH_ACK);
    extPin <= 1'b0;
    repeat (5) @(posedge mclk);
    chk("pin reset", 32'(deviceReset), 32'h1);
    extPin <= 1'b1;
    repeat (5) @(posedge mclk);
    xfer(CMD_RD_THRESH, 8'h64);
    tally_and_finish();
  end
endmodule // tb
